// ===== rtl/crcu_pkg.sv
// Constants and types for the counter remote command unit
// Functional notes
// - Hold extended-function result until queried, no overwrite
// - Talk-only mode never outputs extended results
// - Numeric replies are exactly 24 characters
// - Spaces, sign, digit, point, digits, E, exponent, CRLF
// - Drop lone point; zero lead digit only
// - Number right-justified in 17-character data field
// - Two exponent digits with E and sign
// - Error suspends measurement, commands still executed
// - Clears: device clear, init, reset, clear, panel
// - Error query reports number, keeps error state
// - Status error bit; lingers briefly after init
// - Auto command selects input one, aborts cycle
// - Averaging only for pulse functions, max 9999
// - Instrument clear aborts, clears errors, flushes buffers
// - Step count max 99, cancels times, default 0
// - Event delta max 999999, cancels times, default 0
// - Message takes 48, shows 24, periods merge
// - Message overrides readouts; removal conditions; blank string
// - Fast readout: seven digits, EOI on last
// - Fast mode freezes status, blanks display after 10 min
// - Reject functions 1, 41-43, 80; failures not errors
// - Lockouts 98/99 ignore off; init or standby clears
package crcu_pkg;
  localparam int CRCU_REPLY_LEN = 24;
  localparam int CRCU_FIELD_LEN = 17;
  localparam int CRCU_FAST_LEN = 7;
  localparam int CRCU_MAX_DIGITS = 15;
  localparam int CRCU_DISP_SHOW = 24;
  localparam logic [5:0] CRCU_DISP_ACCEPT = 6'h30;
  localparam logic [4:0] CRCU_POS_E = 5'h12;
  localparam logic [4:0] CRCU_POS_ESIGN = 5'h13;
  localparam logic [4:0] CRCU_POS_EHI = 5'h14;
  localparam logic [4:0] CRCU_POS_ELO = 5'h15;
  localparam logic [4:0] CRCU_POS_CR = 5'h16;
  localparam logic [4:0] CRCU_POS_LF = 5'h17;
  localparam logic [4:0] CRCU_FIELD_END = 5'h12;
  localparam logic [4:0] CRCU_LEN_REPLY = 5'h18;
  localparam logic [4:0] CRCU_LEN_FAST = 5'h07;
  localparam logic [7:0] CRCU_CH_SP = 8'h20;
  localparam logic [7:0] CRCU_CH_MINUS = 8'h2d;
  localparam logic [7:0] CRCU_CH_PLUS = 8'h2b;
  localparam logic [7:0] CRCU_CH_DOT = 8'h2e;
  localparam logic [7:0] CRCU_CH_ZERO = 8'h30;
  localparam logic [7:0] CRCU_CH_E = 8'h45;
  localparam logic [7:0] CRCU_CH_CR = 8'h0d;
  localparam logic [7:0] CRCU_CH_LF = 8'h0a;
  localparam logic [13:0] CRCU_AVERAGING_COUNT_COMMAND_MAX = 14'h270f;
  localparam logic [6:0] CRCU_STEP_MAX = 7'h63;
  localparam logic [19:0] CRCU_DELTA_MAX = 20'hf423f;
  localparam logic [6:0] CRCU_EF_ONE = 7'h01;
  localparam logic [6:0] CRCU_EF_BAND_LO = 7'h29;
  localparam logic [6:0] CRCU_EF_BAND_HI = 7'h2b;
  localparam logic [6:0] CRCU_EF_EIGHTY = 7'h50;
  localparam logic [6:0] CRCU_EF_MAX = 7'h63;
  localparam logic [6:0] CRCU_EF_KEY_LOCK = 7'h62;
  localparam logic [6:0] CRCU_EF_DISP_LOCK = 7'h63;
  localparam logic [2:0] CRCU_ERR_RANGE = 3'h3;
  localparam longint CRCU_CLK_HZ = 20000000;
  localparam longint CRCU_CLK_NS = 50;
  localparam longint CRCU_BLANK_MIN = 10;
  localparam longint CRCU_BLANK_CYC = CRCU_BLANK_MIN * 60 * CRCU_CLK_HZ;
  localparam longint CRCU_INIT_HOLD_NS = 1000;
  localparam longint CRCU_INIT_HOLD_CYC = (CRCU_INIT_HOLD_NS + CRCU_CLK_NS - 1) / CRCU_CLK_NS;
  typedef enum logic [2:0] {
    CRCU_FN_FREQ = 3'b000,
    CRCU_FN_PULSE_WIDTH = 3'b001,
    CRCU_FN_OFF_TIME = 3'b010,
    CRCU_FN_REP_FREQ = 3'b011,
    CRCU_FN_REP_INTERVAL = 3'b100
  } crcu_func_e;
endpackage

// ===== rtl/crcu_top.sv
// Remote command and reply unit of the microwave counter
`timescale 1ns/1ns
module crcu_top
  import crcu_pkg::*;
#(
  parameter logic [33:0] BLANK_CYCLES = CRCU_BLANK_CYC[33:0]
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic talk_addressed_i,
  input wire logic talk_only_i,
  input wire logic byte_taken_i,
  input wire logic meas_done_i,
  input wire logic meas_neg_i,
  input wire logic [3:0] meas_ndig_i,
  input wire logic [59:0] meas_digits_i,
  input wire logic meas_exp_neg_i,
  input wire logic [7:0] meas_exp_i,
  input wire logic [27:0] fast_digits_i,
  input wire logic ext_function_result_query_done_i,
  input wire logic [191:0] ext_function_result_query_result_i,
  input wire logic ext_function_result_query_query_i,
  input wire logic err_query_i,
  input wire logic err_event_i,
  input wire logic [2:0] err_num_i,
  input wire logic device_clear_i,
  input wire logic init_cmd_i,
  input wire logic reset_cmd_i,
  input wire logic instrument_clear_command_i,
  input wire logic panel_reset_key_i,
  input wire logic auto_cmd_i,
  input wire logic [2:0] meas_func_i,
  input wire logic averaging_count_command_i,
  input wire logic [13:0] averaging_count_command_value_i,
  input wire logic profile_step_count_i,
  input wire logic [6:0] step_value_i,
  input wire logic profile_event_delta_i,
  input wire logic [19:0] delta_value_i,
  input wire logic profile_time_set_i,
  input wire logic ext_function_select_i,
  input wire logic [6:0] ext_function_result_query_num_i,
  input wire logic ext_function_result_query_off_i,
  input wire logic standby_i,
  input wire logic fast_on_i,
  input wire logic fast_off_i,
  input wire logic disp_start_i,
  input wire logic disp_char_valid_i,
  input wire logic [7:0] disp_char_i,
  input wire logic disp_end_i,
  input wire logic msg_clear_key_i,
  output logic [7:0] bus_byte_o,
  output logic bus_valid_o,
  output logic bus_eoi_o,
  output logic measure_enable_o,
  output logic status_error_o,
  output logic [2:0] error_num_o,
  output logic local_o,
  output logic abort_o,
  output logic input_one_auto_o,
  output logic [13:0] averaging_count_command_count_o,
  output logic [6:0] step_count_o,
  output logic [19:0] event_delta_o,
  output logic profile_times_valid_o,
  output logic [6:0] ext_function_result_query_active_o,
  output logic ext_function_result_query_reject_o,
  output logic key_lock_o,
  output logic disp_lock_o,
  output logic fast_mode_o,
  output logic annunc_update_o,
  output logic display_blank_o,
  output logic msg_active_o,
  output logic [191:0] msg_text_o,
  output logic [23:0] msg_dots_o
);

  // One character of the numeric reply at position pos
  function automatic logic [7:0] num_char(input logic [4:0] pos, input logic neg, input logic [3:0] nd_in,
                                          input logic [59:0] dig, input logic eneg, input logic [7:0] ex);
    logic [3:0] nd;
    logic [4:0] len;
    logic [4:0] start;
    logic [4:0] k;
    nd = (nd_in == 4'h0) ? 4'h1 : nd_in;
    len = 5'(nd) + 5'h1 + ((nd > 4'h1) ? 5'h1 : 5'h0);
    start = CRCU_FIELD_END - len;
    k = pos - start - 5'h2;
    if (pos == CRCU_POS_CR) num_char = CRCU_CH_CR;
    else if (pos == CRCU_POS_LF) num_char = CRCU_CH_LF;
    else if (pos == CRCU_POS_E) num_char = CRCU_CH_E;
    else if (pos == CRCU_POS_ESIGN) num_char = eneg ? CRCU_CH_MINUS : CRCU_CH_PLUS;
    else if (pos == CRCU_POS_EHI) num_char = CRCU_CH_ZERO + {4'h0, ex[7:4]};
    else if (pos == CRCU_POS_ELO) num_char = CRCU_CH_ZERO + {4'h0, ex[3:0]};
    else if (pos < start) num_char = CRCU_CH_SP;
    else if (pos == start) num_char = neg ? CRCU_CH_MINUS : CRCU_CH_SP;
    else if (pos == start + 5'h1) num_char = CRCU_CH_ZERO + {4'h0, dig[3:0]};
    else if (pos == start + 5'h2) num_char = CRCU_CH_DOT;
    else num_char = CRCU_CH_ZERO + {4'h0, dig[4*k+:4]};
  endfunction

  // Reply buffer and drain state
  logic [7:0] buf_mem [CRCU_REPLY_LEN];
  logic [4:0] buf_len;
  logic [4:0] buf_idx;
  logic buf_meas;
  logic buf_fast;
  logic [191:0] ext_function_result_query_hold;
  logic ext_function_result_query_pending;
  logic err_state;
  logic [2:0] err_num;
  logic [7:0] init_hold;
  logic [33:0] blank_cnt;
  logic [5:0] disp_cnt;
  logic [4:0] disp_pos;
  logic disp_open;

  // Numeric replies formatted per position; the error reply reuses the same formatter
  logic [7:0] meas_chr [CRCU_REPLY_LEN];
  logic [7:0] err_chr [CRCU_REPLY_LEN];
  genvar gp;
  generate
    for (gp = 0; gp < CRCU_REPLY_LEN; gp++) begin : g_fmt
      assign meas_chr[gp] = num_char(5'(gp), meas_neg_i, meas_ndig_i, meas_digits_i, meas_exp_neg_i, meas_exp_i);
      assign err_chr[gp] = num_char(5'(gp), 1'b0, 4'h1, {57'h0, err_num}, 1'b0, 8'h00);
    end
  endgenerate

  // Command decode
  wire clear_all = device_clear_i | init_cmd_i | reset_cmd_i | instrument_clear_command_i | panel_reset_key_i;
  wire flush = device_clear_i | instrument_clear_command_i;
  wire buf_empty = (buf_idx == buf_len);
  wire pulse_func = (meas_func_i == CRCU_FN_PULSE_WIDTH) || (meas_func_i == CRCU_FN_OFF_TIME) ||
                    (meas_func_i == CRCU_FN_REP_FREQ) || (meas_func_i == CRCU_FN_REP_INTERVAL);
  wire averaging_count_command_ok = averaging_count_command_i && pulse_func && (averaging_count_command_value_i <= CRCU_AVERAGING_COUNT_COMMAND_MAX);
  wire averaging_count_command_range = averaging_count_command_i && pulse_func && (averaging_count_command_value_i > CRCU_AVERAGING_COUNT_COMMAND_MAX);
  wire step_ok = profile_step_count_i && (step_value_i <= CRCU_STEP_MAX);
  wire delta_ok = profile_event_delta_i && (delta_value_i <= CRCU_DELTA_MAX);
  wire range_err = averaging_count_command_range | (profile_step_count_i & ~step_ok) | (profile_event_delta_i & ~delta_ok);
  wire ef_bad = (ext_function_result_query_num_i == CRCU_EF_ONE) || (ext_function_result_query_num_i == CRCU_EF_EIGHTY) || (ext_function_result_query_num_i > CRCU_EF_MAX) ||
                ((ext_function_result_query_num_i >= CRCU_EF_BAND_LO) && (ext_function_result_query_num_i <= CRCU_EF_BAND_HI));
  wire ef_take = ext_function_select_i & ~ef_bad;
  wire load_ext_function_result_query = ext_function_result_query_query_i & ext_function_result_query_pending & ~talk_only_i;
  wire load_err = err_query_i & ~load_ext_function_result_query;
  // Measurements only replace an unread measurement, never a query reply
  wire load_meas = meas_done_i & ~err_state & talk_addressed_i & (buf_empty | buf_meas) & ~load_ext_function_result_query & ~load_err;
  wire load_any = load_ext_function_result_query | load_err | load_meas;
  wire drain_go = talk_addressed_i & ~bus_valid_o & ~buf_empty & ~load_any;
  wire [4:0] next_len = load_meas ? (fast_mode_o ? CRCU_LEN_FAST : CRCU_LEN_REPLY) : CRCU_LEN_REPLY;

  // Reply buffer contents
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < CRCU_REPLY_LEN; i++) begin
      // A byte on offer refuses the load, so the contents must not move under it
      if (bus_valid_o) buf_mem[i] <= buf_mem[i];
      else if (load_ext_function_result_query) buf_mem[i] <= ext_function_result_query_hold[8*i+:8];
      else if (load_err) buf_mem[i] <= err_chr[i];
      else if (load_meas && fast_mode_o && i < CRCU_FAST_LEN)
        buf_mem[i] <= CRCU_CH_ZERO + {4'h0, fast_digits_i[4*(CRCU_FAST_LEN-1-i)+:4]};
      else if (load_meas && !fast_mode_o) buf_mem[i] <= meas_chr[i];
    end
  end

  // Buffer pointers and bus byte handshake
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_len <= 5'h00;
      buf_idx <= 5'h00;
      buf_meas <= 1'b0;
      buf_fast <= 1'b0;
      bus_valid_o <= 1'b0;
      bus_byte_o <= 8'h00;
      bus_eoi_o <= 1'b0;
    end else if (flush) begin
      buf_len <= 5'h00;
      buf_idx <= 5'h00;
      buf_meas <= 1'b0;
      bus_valid_o <= 1'b0;
      bus_eoi_o <= 1'b0;
    end else if (load_any && !bus_valid_o) begin
      buf_len <= next_len;
      buf_idx <= 5'h00;
      buf_meas <= load_meas;
      buf_fast <= load_meas & fast_mode_o;
    end else if (drain_go) begin
      bus_byte_o <= buf_mem[buf_idx];
      bus_eoi_o <= buf_fast && (buf_idx == buf_len - 5'h1);
      bus_valid_o <= 1'b1;
    end else if (bus_valid_o && byte_taken_i) begin
      bus_valid_o <= 1'b0;
      bus_eoi_o <= 1'b0;
      buf_idx <= buf_idx + 5'h1;
    end
  end

  // Extended-function result holding register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_function_result_query_hold <= 192'h0;
      ext_function_result_query_pending <= 1'b0;
    end else if (ext_function_result_query_done_i && !ext_function_result_query_pending) begin
      ext_function_result_query_hold <= ext_function_result_query_result_i;
      ext_function_result_query_pending <= 1'b1;
    end else if (load_ext_function_result_query && !bus_valid_o) begin
      ext_function_result_query_pending <= 1'b0;
    end
  end

  // Error state; a new error wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_state <= 1'b0;
      err_num <= 3'h0;
      init_hold <= 8'h00;
    end else begin
      if (err_event_i || range_err) begin
        err_state <= 1'b1;
        err_num <= range_err ? CRCU_ERR_RANGE : err_num_i;
      end else if (clear_all) begin
        err_state <= 1'b0;
        err_num <= 3'h0;
      end
      if (init_cmd_i && err_state) init_hold <= 8'(CRCU_INIT_HOLD_CYC);
      else if (init_hold != 8'h00) init_hold <= init_hold - 8'h01;
    end
  end

  // Status outputs; fast mode freezes the status bit and annunciators
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_error_o <= 1'b0;
      error_num_o <= 3'h0;
      measure_enable_o <= 1'b1;
      annunc_update_o <= 1'b1;
      local_o <= 1'b1;
      abort_o <= 1'b0;
    end else begin
      if (!fast_mode_o) status_error_o <= err_state | (init_hold != 8'h00);
      error_num_o <= err_num;
      measure_enable_o <= ~err_state;
      annunc_update_o <= ~fast_mode_o;
      if (panel_reset_key_i) local_o <= 1'b1;
      else if (talk_addressed_i) local_o <= 1'b0;
      abort_o <= auto_cmd_i | clear_all;
    end
  end

  // Measurement settings and profile parameters
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      input_one_auto_o <= 1'b0;
      averaging_count_command_count_o <= 14'h0000;
      step_count_o <= 7'h00;
      event_delta_o <= 20'h00000;
      profile_times_valid_o <= 1'b0;
    end else if (init_cmd_i) begin
      step_count_o <= 7'h00;
      event_delta_o <= 20'h00000;
      profile_times_valid_o <= 1'b0;
    end else begin
      if (auto_cmd_i) input_one_auto_o <= 1'b1;
      if (averaging_count_command_ok) averaging_count_command_count_o <= averaging_count_command_value_i;
      if (step_ok) step_count_o <= step_value_i;
      if (delta_ok) event_delta_o <= delta_value_i;
      if (step_ok || delta_ok) profile_times_valid_o <= 1'b0;
      else if (profile_time_set_i) profile_times_valid_o <= 1'b1;
    end
  end

  // Extended function selection and lockouts
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_function_result_query_active_o <= 7'h00;
      ext_function_result_query_reject_o <= 1'b0;
      key_lock_o <= 1'b0;
      disp_lock_o <= 1'b0;
    end else begin
      ext_function_result_query_reject_o <= ext_function_select_i & ef_bad;
      if (init_cmd_i || standby_i) begin
        ext_function_result_query_active_o <= 7'h00;
        key_lock_o <= 1'b0;
        disp_lock_o <= 1'b0;
      end else if (ef_take) begin
        ext_function_result_query_active_o <= ext_function_result_query_num_i;
        if (ext_function_result_query_num_i == CRCU_EF_KEY_LOCK) key_lock_o <= 1'b1;
        if (ext_function_result_query_num_i == CRCU_EF_DISP_LOCK) disp_lock_o <= 1'b1;
      end else if (ext_function_result_query_off_i) begin
        ext_function_result_query_active_o <= 7'h00; // Lock flags deliberately untouched
      end
    end
  end

  // Fast readout mode and its display blanking timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_mode_o <= 1'b0;
      blank_cnt <= 34'h0;
      display_blank_o <= 1'b0;
    end else begin
      if (fast_on_i) fast_mode_o <= 1'b1;
      else if (fast_off_i || init_cmd_i) fast_mode_o <= 1'b0;
      if (!fast_mode_o) blank_cnt <= 34'h0;
      else if (blank_cnt != BLANK_CYCLES) blank_cnt <= blank_cnt + 34'h1;
      display_blank_o <= fast_mode_o && (blank_cnt == BLANK_CYCLES);
    end
  end

  // Remote message capture; periods fold into the previous character
  wire disp_is_dot = (disp_char_i == CRCU_CH_DOT) && (disp_pos != 5'h00);
  wire disp_keep = disp_open & disp_char_valid_i & (disp_cnt < CRCU_DISP_ACCEPT);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      msg_text_o <= {CRCU_DISP_SHOW{CRCU_CH_SP}};
      msg_dots_o <= 24'h000000;
      msg_active_o <= 1'b0;
      disp_cnt <= 6'h00;
      disp_pos <= 5'h00;
      disp_open <= 1'b0;
    end else if (init_cmd_i || msg_clear_key_i) begin
      msg_active_o <= 1'b0;
      disp_open <= 1'b0;
    end else if (disp_start_i) begin
      msg_text_o <= {CRCU_DISP_SHOW{CRCU_CH_SP}};
      msg_dots_o <= 24'h000000;
      disp_cnt <= 6'h00;
      disp_pos <= 5'h00;
      disp_open <= 1'b1;
    end else if (disp_keep) begin
      disp_cnt <= disp_cnt + 6'h01;
      if (disp_is_dot) msg_dots_o[disp_pos-5'h1] <= 1'b1;
      else if (disp_pos < 5'(CRCU_DISP_SHOW)) begin
        msg_text_o[8*disp_pos+:8] <= disp_char_i;
        disp_pos <= disp_pos + 5'h1;
      end
    end else if (disp_end_i && disp_open) begin
      disp_open <= 1'b0;
      msg_active_o <= (disp_cnt != 6'h00);
    end
  end

  // Checks kept beside the logic
  a_reply_length: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (load_err && !bus_valid_o && !flush) |=> (buf_len == CRCU_LEN_REPLY)) else $error("reply not 24 chars");
  a_err_query_keeps: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (err_state && err_query_i && !clear_all) |=> err_state) else $error("error query cleared error");
  a_talk_only_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ext_function_result_query_pending && talk_only_i && !ext_function_result_query_done_i) |=> ext_function_result_query_pending) else $error("result left in talk-only");
  a_meas_suspend: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    err_state |=> !measure_enable_o) else $error("measure not suspended");
  a_clear_errors: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clear_all && !err_event_i && !range_err) |=> !err_state) else $error("error not cleared");
  a_step_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    step_count_o <= CRCU_STEP_MAX) else $error("step count over limit");
  a_delta_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    event_delta_o <= CRCU_DELTA_MAX) else $error("delta over limit");
  a_averaging_count_command_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    averaging_count_command_count_o <= CRCU_AVERAGING_COUNT_COMMAND_MAX) else $error("average over limit");
  a_lock_off_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (key_lock_o && ext_function_result_query_off_i && !init_cmd_i && !standby_i) |=> key_lock_o) else $error("lock dropped");
  a_talk_drain: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(bus_valid_o) |-> $past(talk_addressed_i)) else $error("byte offered while not talker");
  a_fast_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (fast_mode_o && $past(fast_mode_o)) |-> $stable(status_error_o)) else $error("status moved in fast mode");

endmodule // crcu_top

// ===== test/crcu_ctrl_model.sv
// Bus controller model that takes reply bytes from the command unit
`timescale 1ns/1ns
module crcu_ctrl_model (
  input wire logic clk_i,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  input wire logic eoi_i,
  input wire logic [3:0] stall_i,
  output logic taken_o
);
  logic [7:0] got_q[$];
  logic eoi_q[$];
  logic [3:0] wait_cnt = 4'h0;
  initial taken_o = 1'b0;
  // One byte per handshake; stall_i mimics a slow listener
  always @(posedge clk_i) begin
    if (valid_i === 1'b1 && !taken_o && wait_cnt >= stall_i) begin
      got_q.push_back(byte_i);
      eoi_q.push_back(eoi_i);
      taken_o <= #5 1'b1;
      wait_cnt <= 4'h0;
    end else begin
      taken_o <= #5 1'b0;
      wait_cnt <= (valid_i === 1'b1) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // crcu_ctrl_model

// ===== test/crcu_top_tb_top.sv
// Self-checking bench for the counter remote command unit
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, (a), (b)); end end
`define PULSE(s) begin @(posedge clk_i); #5 s = 1'b1; @(posedge clk_i); #5 s = 1'b0; end
module crcu_top_tb_top import crcu_pkg::*;;
  logic clk_i = 0, rst_b_i = 0, talk_addressed_i = 0, talk_only_i = 0, byte_taken_i, meas_done_i = 0;
  logic meas_neg_i = 0, meas_exp_neg_i = 0, ext_function_result_query_done_i = 0, ext_function_result_query_query_i = 0, err_query_i = 0, err_event_i = 0;
  logic init_cmd_i = 0, auto_cmd_i = 0, averaging_count_command_i = 0, profile_step_count_i = 0;
  logic profile_event_delta_i = 0, profile_time_set_i = 0, ext_function_select_i = 0, ext_function_result_query_off_i = 0;
  logic standby_i = 0, fast_on_i = 0, fast_off_i = 0, disp_start_i = 0, disp_char_valid_i = 0;
  logic disp_end_i = 0, msg_clear_key_i = 0;
  logic device_clear_i, reset_cmd_i, panel_reset_key_i, instrument_clear_command_i;
  logic [3:0] clr_v = 4'h0, stall = 4'h0, meas_ndig_i = 4'h0;
  logic [59:0] meas_digits_i = 60'h0;
  logic [7:0] meas_exp_i = 8'h0, disp_char_i = 8'h0;
  logic [27:0] fast_digits_i = 28'h0;
  logic [191:0] ext_function_result_query_result_i = 192'h0;
  logic [2:0] err_num_i = 3'h0, meas_func_i = 3'h0;
  logic [13:0] averaging_count_command_value_i = 14'h0;
  logic [6:0] step_value_i = 7'h0, ext_function_result_query_num_i = 7'h0;
  logic [19:0] delta_value_i = 20'h0;
  logic [7:0] bus_byte_o;
  logic bus_valid_o, bus_eoi_o, measure_enable_o, status_error_o, local_o, abort_o, input_one_auto_o;
  logic profile_times_valid_o, ext_function_result_query_reject_o, key_lock_o, disp_lock_o, fast_mode_o, annunc_update_o;
  logic display_blank_o, msg_active_o;
  logic [2:0] error_num_o;
  logic [13:0] averaging_count_command_count_o;
  logic [6:0] step_count_o, ext_function_result_query_active_o;
  logic [19:0] event_delta_o;
  logic [191:0] msg_text_o;
  logic [23:0] msg_dots_o;
  int num_errors = 0, n_compared = 0;
  string s24 = "ABCDEFGHIJKLMNOPQRSTUVWX";

  // Four of the five clear sources share one vector so a loop can walk them
  assign {device_clear_i, reset_cmd_i, panel_reset_key_i, instrument_clear_command_i} = clr_v;

  crcu_top #(.BLANK_CYCLES(34'h64)) DUT (.*);
  crcu_ctrl_model ctl (.clk_i, .byte_i(bus_byte_o), .valid_i(bus_valid_o), .eoi_i(bus_eoi_o),
    .stall_i(stall), .taken_o(byte_taken_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("errors %0d, compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  function automatic string pad(input int n, input string s);
    repeat (n) s = {" ", s};
    return s;
  endfunction

  // Waits for a whole reply, then a few idle cycles to catch extra bytes
  task automatic chk_reply(input string s, input bit fast);
    int i;
    for (i = 0; i < 300 && ctl.got_q.size() < s.len(); i++) cyc(1);
    cyc(8);
    `CHK(ctl.got_q.size(), s.len())
    for (i = 0; i < s.len() && i < ctl.got_q.size(); i++) begin
      `CHK(ctl.got_q[i], s[i])
      `CHK(ctl.eoi_q[i], fast && i == s.len() - 1)
    end
    ctl.got_q.delete();
    ctl.eoi_q.delete();
  endtask

  task automatic meas(input logic ng, input logic [3:0] nd, input logic [59:0] dg, input logic en,
    input logic [7:0] ex);
    meas_neg_i = ng;
    meas_ndig_i = nd;
    meas_digits_i = dg;
    meas_exp_neg_i = en;
    meas_exp_i = ex;
    `PULSE(meas_done_i)
  endtask

  task automatic sel(input logic [6:0] n);
    ext_function_result_query_num_i = n;
    `PULSE(ext_function_select_i)
  endtask

  task automatic msg(input string s);
    `PULSE(disp_start_i)
    for (int i = 0; i < s.len(); i++) begin
      disp_char_i = s[i];
      `PULSE(disp_char_valid_i)
    end
    `PULSE(disp_end_i)
    cyc(1);
  endtask

  task automatic t_meas;
    talk_addressed_i = 1;
    meas(1, 4'h5, 60'h21491, 0, 8'h10);
    chk_reply(pad(11, "-1.9412E+10\015\012"), 0);
    meas(0, 4'h1, 60'h5, 1, 8'h03);
    chk_reply(pad(17, "5E-03\015\012"), 0);
  endtask

  task automatic t_ext_function_result_query;
    talk_addressed_i = 0;
    for (int i = 0; i < 24; i++) ext_function_result_query_result_i[8*i+:8] = s24[i];
    `PULSE(ext_function_result_query_done_i)
    meas(0, 4'h1, 60'h7, 0, 8'h00);
    talk_only_i = 1;
    talk_addressed_i = 1;
    `PULSE(ext_function_result_query_query_i)
    cyc(12);
    `CHK(ctl.got_q.size(), 0)
    talk_only_i = 0;
    `PULSE(ext_function_result_query_query_i)
    chk_reply(s24, 0);
    `PULSE(ext_function_result_query_query_i)
    cyc(12);
    `CHK(ctl.got_q.size(), 0)
  endtask

  // Slow listener on purpose while the fast reply streams out
  task automatic t_fast;
    stall = 4'h3;
    `PULSE(fast_on_i)
    `CHK(fast_mode_o, 1'b1)
    fast_digits_i = 28'h0194125;
    `PULSE(meas_done_i)
    `CHK(annunc_update_o, 1'b0)
    chk_reply("0194125", 1);
    cyc(100);
    `CHK(display_blank_o, 1'b1)
    `PULSE(fast_off_i)
    cyc(1);
    `CHK(fast_mode_o, 1'b0)
    stall = 4'h0;
  endtask

  task automatic t_err;
    err_num_i = 3'h3;
    `PULSE(err_event_i)
    cyc(1);
    `CHK(status_error_o, 1'b1)
    `CHK(measure_enable_o, 1'b0)
    `CHK(error_num_o, 3'h3)
    step_value_i = 7'h23;
    `PULSE(profile_step_count_i)
    `CHK(step_count_o, 7'h23)
    meas(0, 4'h1, 60'h9, 0, 8'h01);
    `PULSE(err_query_i)
    chk_reply(pad(17, "3E+00\015\012"), 0);
    `CHK(status_error_o, 1'b1)
    talk_addressed_i = 0;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) `PULSE(err_event_i)
      cyc(2);
      clr_v = 4'h8 >> k;
      cyc(1);
      clr_v = 4'h0;
      cyc(2);
      `CHK(status_error_o, 1'b0)
    end
    `CHK(local_o, 1'b1)
  endtask

  task automatic t_cmds;
    for (int f = 1; f < 5; f++) begin
      meas_func_i = f[2:0];
      averaging_count_command_value_i = 14'h270a + f[13:0];
      `PULSE(averaging_count_command_i)
      `CHK(averaging_count_command_count_o, 14'h270a + f[13:0])
    end
    averaging_count_command_value_i = 14'h5;
    meas_func_i = CRCU_FN_FREQ;
    `PULSE(averaging_count_command_i)
    `CHK(averaging_count_command_count_o, 14'h270e)
    for (int i = 0; i < 5; i++) begin
      sel(i == 0 ? 7'h01 : (i == 4 ? 7'h50 : 7'h28 + i[6:0]));
      `CHK(ext_function_result_query_reject_o, 1'b1)
    end
    sel(7'h02);
    `CHK(ext_function_result_query_reject_o, 1'b0)
    `CHK(ext_function_result_query_active_o, 7'h02)
    cyc(2);
    `CHK(status_error_o, 1'b0)
    sel(7'h62);
    sel(7'h63);
    `PULSE(ext_function_result_query_off_i)
    `CHK({key_lock_o, disp_lock_o}, 2'b11)
    `PULSE(standby_i)
    `CHK({key_lock_o, disp_lock_o}, 2'b00)
    sel(7'h62);
    `PULSE(auto_cmd_i)
    `CHK({abort_o, input_one_auto_o}, 2'b11)
    `PULSE(profile_time_set_i)
    step_value_i = 7'h63;
    `PULSE(profile_step_count_i)
    `CHK({step_count_o, profile_times_valid_o}, {7'h63, 1'b0})
    step_value_i = 7'h64;
    `PULSE(profile_step_count_i)
    `CHK(step_count_o, 7'h63)
    `PULSE(profile_time_set_i)
    delta_value_i = 20'hf423f;
    `PULSE(profile_event_delta_i)
    `CHK({event_delta_o, profile_times_valid_o}, {20'hf423f, 1'b0})
    delta_value_i = 20'hf4240;
    `PULSE(profile_event_delta_i)
    `CHK(event_delta_o, 20'hf423f)
    cyc(2);
    `PULSE(init_cmd_i)
    `CHK(status_error_o, 1'b1)
    cyc(10);
    `CHK(status_error_o, 1'b1)
    cyc(14);
    `CHK(status_error_o, 1'b0)
    `CHK({step_count_o, event_delta_o, key_lock_o}, 28'h0)
  endtask

  task automatic t_disp;
    msg("H.I");
    `CHK({msg_active_o, msg_text_o[23:0], msg_dots_o[0]}, {1'b1, CRCU_CH_SP, 16'h4948, 1'b1})
    msg("");
    `CHK(msg_active_o, 1'b0)
    msg({s24, "YZ"});
    `CHK(msg_text_o[191:184], 8'h58)
    msg(" ");
    `CHK({msg_active_o, msg_text_o[7:0]}, {1'b1, CRCU_CH_SP})
    `PULSE(msg_clear_key_i)
    cyc(1);
    `CHK(msg_active_o, 1'b0)
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    #5 rst_b_i = 1;
    t_meas();
    t_ext_function_result_query();
    t_fast();
    t_err();
    t_cmds();
    t_disp();
    end_sim();
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial begin
    #(20000 * 50);
    num_errors++;
    end_sim();
  end
endmodule // crcu_top_tb_top
